// ---- hdl/watchdog_pkg.sv ----
// Shared constants and types of the minute or second watchdog
// Functional notes
// - Timeout of 1 to 255 units, one-unit steps
// - Unit bit 7 selects minutes over seconds
// - Reload zero disables; zero after reset
// - Nonzero reload write loads and starts counting
// - Count reaching zero halts and sets status
// - Software sets or clears status bit directly
// - Separate keyboard and mouse restart enables
// - Enabled event reloads count, clears status
// - Both events disabled means no reload
// - Status rising edge can raise interrupt
// - Interrupt routed to configured channel number
// - Routed request follows the status level
// - Force bit 2 zeroes count, sets bit 0
// - Force bit clears itself after acting
package watchdog_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_UNIT = 8'h00;
   localparam logic [7:0] OFS_RELOAD = 8'h04;
   localparam logic [7:0] OFS_EVCFG = 8'h08;
   localparam logic [7:0] OFS_CTRL = 8'h0c;
   localparam logic [7:0] OFS_COUNT = 8'h10;
   localparam logic [7:0] OFS_INT_STATUS = 8'h14;
   localparam logic [7:0] OFS_INT_MASK = 8'h18;
   // Field positions
   localparam int UNIT_MINUTE_BIT = 7;
   localparam int EV_KBD_BIT = 0;
   localparam int EV_MOUSE_BIT = 1;
   localparam int EV_CHAN_LSB = 4;
   localparam int CHAN_W = 4;
   localparam int CTRL_STATUS_BIT = 0;
   localparam int CTRL_FORCE_BIT = 2;
   localparam int INT_TIMEOUT_BIT = 0;
   localparam int INT_RESTART_BIT = 1;
   localparam int INT_W = 2;
   localparam int NUM_CHAN = 16;
   // Reset values
   localparam logic [7:0] RST_UNIT = 8'h00;
   localparam logic [7:0] RST_RELOAD = 8'h00;
   localparam logic [7:0] RST_EVCFG = 8'h00;
   localparam logic [1:0] RST_INT_MASK = 2'h0;
   // Timing
   localparam int CLK_HZ = 100_000_000;
   localparam int UNIT_SECOND_S = 1;
   localparam int SECONDS_PER_MINUTE = 60;
   localparam int SEC_CYCLES = UNIT_SECOND_S * CLK_HZ;
   // Watchdog state
   typedef enum logic [1:0] {
      WD_OFF = 2'b00,
      WD_RUN = 2'b01,
      WD_EXPIRED = 2'b10
   } wd_state_t;
endpackage : watchdog_pkg

// ---- hdl/unit_tick_gen.sv ----
// Prescaler that pulses once per elapsed second or minute
`timescale 1ns/1ns
module unit_tick_gen #(
   parameter int unsigned SEC_CYCLES = watchdog_pkg::SEC_CYCLES
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Control
   input wire logic restart,
   input wire logic run,
   input wire logic minute_mode,
   // One-cycle unit pulse
   output logic tick
);
   import watchdog_pkg::*;

   logic [31:0] cyc_q, cyc_d; // Cycles within the current second
   logic [5:0] sec_q, sec_d; // Seconds within the current minute
   logic sec_end; // Last cycle of a second

   assign sec_end = run && (cyc_q == 32'(SEC_CYCLES - 1));
   // Minute mode fires only on the last second of sixty
   assign tick = sec_end && (!minute_mode || (sec_q == 6'(SECONDS_PER_MINUTE - 1)));

   // Next prescaler values
   always_comb begin
      cyc_d = cyc_q;
      sec_d = sec_q;
      if (restart || !run) begin
         // Reload starts a full unit afresh
         cyc_d = 32'h0;
         sec_d = 6'h0;
      end else if (sec_end) begin
         cyc_d = 32'h0;
         sec_d = (tick || !minute_mode) ? 6'h0 : sec_q + 6'h1;
      end else begin
         cyc_d = cyc_q + 32'h1;
      end
   end

   // Prescaler registers
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cyc_q <= 32'h0;
         sec_q <= 6'h0;
      end else begin
         cyc_q <= cyc_d;
         sec_q <= sec_d;
      end
   end

   AST_TICK_SPACING: assert property (@(posedge ref_clk) disable iff (!reset_n)
      tick |-> (cyc_q == 32'(SEC_CYCLES - 1)) && run)
      else $error("unit tick not at end of second");
   AST_MINUTE_TICK: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (tick && minute_mode) |-> (sec_q == 6'(SECONDS_PER_MINUTE - 1)))
      else $error("minute tick before sixtieth second");
endmodule : unit_tick_gen

// ---- hdl/irq_channel_router.sv ----
// Steers the timeout status level onto one selected interrupt channel
`timescale 1ns/1ns
module irq_channel_router (
   // Source
   input wire logic status,
   input wire logic [watchdog_pkg::CHAN_W-1:0] chan_sel,
   // Channel requests
   output logic [watchdog_pkg::NUM_CHAN-1:0] irq_chan
);
   import watchdog_pkg::*;

   // Channel zero means not mapped; others follow the status level
   for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
      assign irq_chan[i] = (i != 0) && (chan_sel == CHAN_W'(i)) && status;
   end
endmodule : irq_channel_router

// ---- hdl/minute_second_watchdog.sv ----
// Watchdog countdown with register port, restart events and interrupt routing
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ns
module minute_second_watchdog #(
   parameter int unsigned SEC_CYCLES = watchdog_pkg::SEC_CYCLES
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // System restart events
   input wire logic kbd_irq,
   input wire logic mouse_irq,
   // Interrupts
   output logic [watchdog_pkg::NUM_CHAN-1:0] irq_chan,
   output logic irq
);
   import watchdog_pkg::*;

   // Software registers
   logic [7:0] timeout_unit_select_reg_q, timeout_unit_select_reg_d;
   logic [7:0] countdown_reload_value_q, countdown_reload_value_d;
   logic [7:0] watchdog_event_config_q, watchdog_event_config_d;
   logic [INT_W-1:0] int_mask_q, int_mask_d;
   // Block state
   logic [7:0] count_q, count_d; // Remaining units
   logic status_q, status_d; // Timeout status bit
   wd_state_t state_q, state_d; // Off, running or expired
   logic [INT_W-1:0] int_status_q, int_status_d; // Sticky events
   logic kbd_q, kbd_d; // Previous keyboard level
   logic mouse_q, mouse_d; // Previous mouse level
   logic [31:0] rdata_q, rdata_d; // Read data, one cycle late
   // Decodes and events
   logic wr_unit, wr_reload, wr_evcfg, wr_ctrl, wr_int_status, wr_int_mask;
   logic force_to; // Force timeout request
   logic restart_evt; // Enabled keyboard or mouse event
   logic tick; // One unit elapsed
   logic run; // Prescaler runs
   logic load_start; // Counter restarted from a reload
   logic expire; // Count steps from one to zero
   logic status_rise; // Status goes from low to high

   // Write decode
   assign wr_unit = reg_wr && (reg_addr == OFS_UNIT);
   assign wr_reload = reg_wr && (reg_addr == OFS_RELOAD);
   assign wr_evcfg = reg_wr && (reg_addr == OFS_EVCFG);
   assign wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
   assign wr_int_status = reg_wr && (reg_addr == OFS_INT_STATUS);
   assign wr_int_mask = reg_wr && (reg_addr == OFS_INT_MASK);
   // Force is acted on in the write cycle and never stored
   assign force_to = wr_ctrl && reg_wdata[CTRL_FORCE_BIT];
   // Each source has its own enable; both off means no restart
   assign restart_evt = (kbd_irq && !kbd_q && watchdog_event_config_q[EV_KBD_BIT])
      || (mouse_irq && !mouse_q && watchdog_event_config_q[EV_MOUSE_BIT]);
   assign status_rise = status_d && !status_q;

   // Prescaler runs only while counting
   always_comb begin
      case (state_q)
         WD_OFF: run = 1'b0;
         WD_RUN: run = 1'b1;
         WD_EXPIRED: run = 1'b0;
         default: run = 1'b0;
      endcase
   end

   // Unit timebase, seconds or minutes by unit bit 7
   unit_tick_gen #(
      .SEC_CYCLES(SEC_CYCLES)
   ) u_tick (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .restart(load_start),
      .run(run),
      .minute_mode(timeout_unit_select_reg_q[UNIT_MINUTE_BIT]),
      .tick(tick)
   );

   // Routing of the status level to the chosen channel
   irq_channel_router u_router (
      .status(status_q),
      .chan_sel(watchdog_event_config_q[EV_CHAN_LSB +: CHAN_W]),
      .irq_chan(irq_chan)
   );

   // Next register, counter and status values
   always_comb begin
      timeout_unit_select_reg_d = timeout_unit_select_reg_q;
      countdown_reload_value_d = countdown_reload_value_q;
      watchdog_event_config_d = watchdog_event_config_q;
      int_mask_d = int_mask_q;
      count_d = count_q;
      status_d = status_q;
      load_start = 1'b0;
      expire = 1'b0;
      // Edge detectors keep the last pin level
      kbd_d = kbd_irq;
      mouse_d = mouse_irq;
      // Plain configuration writes
      if (wr_unit) begin
         timeout_unit_select_reg_d = reg_wdata[7:0];
      end
      if (wr_evcfg) begin
         watchdog_event_config_d = reg_wdata[7:0];
      end
      if (wr_int_mask) begin
         int_mask_d = reg_wdata[INT_W-1:0];
      end
      // Direct status write, unless expiry, a restart event or a force overrides it
      if (wr_ctrl) begin
         status_d = reg_wdata[CTRL_STATUS_BIT];
      end
      // Counter: 8 bits give 1 to 255 units
      if (wr_reload) begin
         countdown_reload_value_d = reg_wdata[7:0];
         // Zero disables, nonzero loads and starts
         count_d = reg_wdata[7:0];
         load_start = 1'b1;
      end else if (restart_evt) begin
         // Enabled event reloads and clears status
         count_d = countdown_reload_value_q;
         status_d = 1'b0;
         load_start = 1'b1;
      end else if (tick && (count_q != 8'h0)) begin
         count_d = count_q - 8'h1;
         expire = (count_q == 8'h1);
      end
      // Reaching zero halts and sets status; hardware set wins
      if (expire) begin
         status_d = 1'b1;
      end
      // Forced timeout zeroes the count and sets status
      if (force_to) begin
         count_d = 8'h0;
         status_d = 1'b1;
      end
   end

   // State follows count and status
   always_comb begin
      if (count_d != 8'h0) begin
         state_d = WD_RUN;
      end else if (status_d) begin
         state_d = WD_EXPIRED;
      end else begin
         state_d = WD_OFF;
      end
   end

   // Sticky interrupt events; a set beats a write-one clear
   always_comb begin
      int_status_d = int_status_q;
      if (wr_int_status) begin
         int_status_d = int_status_q & ~reg_wdata[INT_W-1:0];
      end
      if (status_rise) begin
         int_status_d[INT_TIMEOUT_BIT] = 1'b1;
      end
      if (restart_evt) begin
         int_status_d[INT_RESTART_BIT] = 1'b1;
      end
   end

   // Read mux; unmapped addresses read zero, force bit reads zero
   always_comb begin
      rdata_d = 32'h0;
      if (reg_rd) begin
         case (reg_addr)
            OFS_UNIT: rdata_d = {24'h0, timeout_unit_select_reg_q};
            OFS_RELOAD: rdata_d = {24'h0, countdown_reload_value_q};
            OFS_EVCFG: rdata_d = {24'h0, watchdog_event_config_q};
            OFS_CTRL: rdata_d = {31'h0, status_q};
            OFS_COUNT: rdata_d = {24'h0, count_q};
            OFS_INT_STATUS: rdata_d = {30'h0, int_status_q};
            OFS_INT_MASK: rdata_d = {30'h0, int_mask_q};
            default: rdata_d = 32'h0;
         endcase
      end
   end

   // All registers; reload is zero after reset
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         timeout_unit_select_reg_q <= RST_UNIT;
         countdown_reload_value_q <= RST_RELOAD;
         watchdog_event_config_q <= RST_EVCFG;
         int_mask_q <= RST_INT_MASK;
         count_q <= 8'h0;
         status_q <= 1'b0;
         state_q <= WD_OFF;
         int_status_q <= 2'h0;
         kbd_q <= 1'b0;
         mouse_q <= 1'b0;
         rdata_q <= 32'h0;
      end else begin
         timeout_unit_select_reg_q <= timeout_unit_select_reg_d;
         countdown_reload_value_q <= countdown_reload_value_d;
         watchdog_event_config_q <= watchdog_event_config_d;
         int_mask_q <= int_mask_d;
         count_q <= count_d;
         status_q <= status_d;
         state_q <= state_d;
         int_status_q <= int_status_d;
         kbd_q <= kbd_d;
         mouse_q <= mouse_d;
         rdata_q <= rdata_d;
      end
   end

   // Read data leave straight from their register
   assign reg_rdata = rdata_q;
   // Level interrupt while any unmasked event stands
   assign irq = |(int_status_q & int_mask_q);

   // Assertions on counter, status, restart events and routing
   // Reload zero keeps the counter at rest
   AST_ZERO_STAYS_OFF: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (countdown_reload_value_q == 8'h0 && count_q == 8'h0 && !wr_reload)
      |=> count_q == 8'h0)
      else $error("disabled watchdog started counting");
   // A zero reload write leaves the timer off
   AST_ZERO_WRITE: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (wr_reload && reg_wdata[7:0] == 8'h0)
      |=> count_q == 8'h0 && state_q != WD_RUN)
      else $error("zero reload did not disable the watchdog");
   // Reload write loads the counter and sets the prescaler running if the value is nonzero
   AST_RELOAD_LOADS: assert property (@(posedge ref_clk) disable iff (!reset_n)
      wr_reload |=> count_q == $past(reg_wdata[7:0]) && run == (count_q != 8'h0))
      else $error("reload write did not load the counter");
   // Last unit sets status and leaves the timer expired
   AST_EXPIRE_SETS: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (tick && count_q == 8'h1 && !reg_wr && !restart_evt)
      |=> count_q == 8'h0 && status_q && state_q == WD_EXPIRED)
      else $error("expiry did not halt and set status");
   // An expired timer stays at zero until reloaded
   AST_EXPIRED_HALTS: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (state_q == WD_EXPIRED && !wr_reload && !restart_evt)
      |=> count_q == 8'h0)
      else $error("expired counter moved without a reload");
   // Software owns the status bit unless expiry, a restart event or a force overrides it
   AST_STATUS_WRITE: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (wr_ctrl && !force_to && !expire && !restart_evt)
      |=> status_q == $past(reg_wdata[CTRL_STATUS_BIT]))
      else $error("status write not applied");
   // A keyboard edge alone restarts only under its enable
   AST_KBD_ENABLE: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (kbd_irq && !kbd_q && !watchdog_event_config_q[EV_KBD_BIT]
      && !(mouse_irq && !mouse_q)) |-> !restart_evt)
      else $error("disabled keyboard event restarted the timer");
   // A mouse edge alone restarts only under its enable
   AST_MOUSE_ENABLE: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (mouse_irq && !mouse_q && !watchdog_event_config_q[EV_MOUSE_BIT]
      && !(kbd_irq && !kbd_q)) |-> !restart_evt)
      else $error("disabled mouse event restarted the timer");
   // Enabled event reloads and clears the status
   AST_RESTART_RELOAD: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (restart_evt && !reg_wr)
      |=> count_q == countdown_reload_value_q && !status_q)
      else $error("restart event did not reload");
   // A taken restart is recorded among the sticky events
   AST_RESTART_EVENT: assert property (@(posedge ref_clk) disable iff (!reset_n)
      restart_evt |=> int_status_q[INT_RESTART_BIT])
      else $error("restart event not recorded");
   // With both restarts off only ticks and writes move the count
   AST_NO_RESTART: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (watchdog_event_config_q[1:0] == 2'b00 && !reg_wr && !tick)
      |=> $stable(count_q))
      else $error("count changed with restarts disabled");
   // Status rise is latched as a timeout event
   AST_RISE_EVENT: assert property (@(posedge ref_clk) disable iff (!reset_n)
      $rose(status_q) |-> int_status_q[INT_TIMEOUT_BIT])
      else $error("status rise not recorded");
   // A latched timeout event stays until software clears it
   AST_EVENT_STICKY: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (int_status_q[INT_TIMEOUT_BIT] && !wr_int_status)
      |=> int_status_q[INT_TIMEOUT_BIT])
      else $error("timeout event dropped without a clear");
   // Only the selected channel follows the status level
   AST_ROUTE_LEVEL: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (watchdog_event_config_q[EV_CHAN_LSB +: CHAN_W] != 4'h0)
      |-> irq_chan[watchdog_event_config_q[EV_CHAN_LSB +: CHAN_W]] == status_q
      && $countones(irq_chan) <= 1)
      else $error("channel request does not follow status");
   // Forced timeout zeroes the count and sets status
   AST_FORCE: assert property (@(posedge ref_clk) disable iff (!reset_n)
      force_to |=> count_q == 8'h0 && status_q && state_q == WD_EXPIRED)
      else $error("forced timeout not taken");
   // Force bit never reads back set
   AST_FORCE_SELF_CLEAR: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (reg_rd && reg_addr == OFS_CTRL) |=> !reg_rdata[CTRL_FORCE_BIT])
      else $error("force bit read back set");
   // Each tick without a reload write, restart event or force takes exactly one unit off the count
   AST_RANGE: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (tick && count_q != 8'h0 && !reg_wr && !restart_evt)
      |=> count_q == $past(count_q) - 8'h1)
      else $error("counter did not step by one unit");

   // Main scenarios
   COV_EXPIRE: cover property (@(posedge ref_clk) disable iff (!reset_n) expire);
   COV_FORCE: cover property (@(posedge ref_clk) disable iff (!reset_n) force_to);
   COV_RESTART: cover property (@(posedge ref_clk) disable iff (!reset_n)
      restart_evt && count_q != 8'h0);
   COV_IRQ: cover property (@(posedge ref_clk) disable iff (!reset_n) $rose(irq));
   COV_MINUTE: cover property (@(posedge ref_clk) disable iff (!reset_n)
      tick && timeout_unit_select_reg_q[UNIT_MINUTE_BIT]);
endmodule : minute_second_watchdog

// ---- tb/tb_top.sv ----
// Self-checking testbench of the minute or second watchdog
`timescale 1ns/1ns
module tb_top;
   import watchdog_pkg::*;
   // Short prescaler so one second is four clocks
   localparam int unsigned TB_SEC = 4;
   // Clock, reset and register port
   logic ref_clk;
   logic reset_n;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_rdata;
   // Restart events and interrupts
   logic kbd_irq;
   logic mouse_irq;
   logic [NUM_CHAN-1:0] irq_chan;
   logic irq;
   // Bookkeeping
   int fail_count;
   int n_compared;

   // Device under test
   minute_second_watchdog #(.SEC_CYCLES(TB_SEC)) uut (
      .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .kbd_irq(kbd_irq),
      .mouse_irq(mouse_irq), .irq_chan(irq_chan), .irq(irq));

   // Free-running 100 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Compares one value and counts the result
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // One-cycle register write
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr

   // One-cycle register read, data taken in the following cycle
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd

   // Read and compare in one step
   task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd(a, d);
      chk(what, exp, d);
   endtask : rdc

   // One rising edge on a restart input
   task automatic pulse(input bit mouse);
      @(posedge ref_clk);
      if (mouse) mouse_irq <= 1'b1;
      else kbd_irq <= 1'b1;
      @(posedge ref_clk);
      kbd_irq <= 1'b0;
      mouse_irq <= 1'b0;
   endtask : pulse

   // Reset values and an unmapped address
   task automatic t_reset_values();
      rdc("unit", OFS_UNIT, 32'h0);
      rdc("reload", OFS_RELOAD, 32'h0);
      rdc("evcfg", OFS_EVCFG, 32'h0);
      rdc("ctrl", OFS_CTRL, 32'h0);
      rdc("count", OFS_COUNT, 32'h0);
      rdc("unmapped", 8'h1c, 32'h0);
      chk("irq_chan", 32'h0, {16'h0, irq_chan});
   endtask : t_reset_values

   // Seconds countdown with one decrement every four clocks
   task automatic t_countdown();
      wr(OFS_RELOAD, 32'h03);
      rdc("count loaded", OFS_COUNT, 32'h03);
      repeat (2) @(posedge ref_clk);
      rdc("count one down", OFS_COUNT, 32'h02);
      repeat (2) @(posedge ref_clk);
      rdc("count two down", OFS_COUNT, 32'h01);
      rdc("status still clear", OFS_CTRL, 32'h0);
      rdc("count expired", OFS_COUNT, 32'h0);
      rdc("status set", OFS_CTRL, 32'h01);
      repeat (8) @(posedge ref_clk);
      rdc("count halted", OFS_COUNT, 32'h0);
   endtask : t_countdown

   // Minute unit stretches each step sixty times
   task automatic t_minutes();
      wr(OFS_CTRL, 32'h0);
      wr(OFS_UNIT, 32'h80);
      rdc("unit readback", OFS_UNIT, 32'h80);
      wr(OFS_RELOAD, 32'h01);
      repeat (200) @(posedge ref_clk);
      rdc("minute count", OFS_COUNT, 32'h01);
      repeat (60) @(posedge ref_clk);
      rdc("minute expired", OFS_COUNT, 32'h0);
      wr(OFS_UNIT, 32'h00);
   endtask : t_minutes

   // Reload zero keeps the timer off
   task automatic t_disable();
      wr(OFS_CTRL, 32'h0);
      wr(OFS_RELOAD, 32'h05);
      wr(OFS_RELOAD, 32'h00);
      repeat (30) @(posedge ref_clk);
      rdc("disabled count", OFS_COUNT, 32'h0);
      rdc("disabled status", OFS_CTRL, 32'h0);
   endtask : t_disable

   // Forced timeout and direct status access
   task automatic t_force();
      wr(OFS_RELOAD, 32'hc8);
      wr(OFS_CTRL, 32'h04);
      rdc("forced count", OFS_COUNT, 32'h0);
      rdc("forced ctrl", OFS_CTRL, 32'h01);
      wr(OFS_CTRL, 32'h00);
      rdc("status cleared", OFS_CTRL, 32'h0);
      wr(OFS_CTRL, 32'h01);
      rdc("status set direct", OFS_CTRL, 32'h01);
   endtask : t_force

   // Keyboard and mouse restarts under their enables
   task automatic t_events();
      wr(OFS_RELOAD, 32'hc8);
      wr(OFS_EVCFG, 32'h01);
      wr(OFS_CTRL, 32'h04);
      pulse(1'b1);
      rdc("mouse off", OFS_COUNT, 32'h0);
      pulse(1'b0);
      rdc("kbd reload", OFS_COUNT, 32'hc8);
      rdc("kbd status", OFS_CTRL, 32'h0);
      wr(OFS_EVCFG, 32'h02);
      wr(OFS_CTRL, 32'h04);
      pulse(1'b0);
      rdc("kbd off", OFS_COUNT, 32'h0);
      pulse(1'b1);
      rdc("mouse reload", OFS_COUNT, 32'hc8);
      wr(OFS_EVCFG, 32'h00);
      wr(OFS_CTRL, 32'h04);
      pulse(1'b0);
      pulse(1'b1);
      rdc("both off", OFS_COUNT, 32'h0);
      rdc("both off status", OFS_CTRL, 32'h01);
      rdc("restart recorded", OFS_INT_STATUS, 32'h3);
   endtask : t_events

   // Interrupt routing, masking and clearing
   task automatic t_irq();
      wr(OFS_CTRL, 32'h0);
      wr(OFS_INT_STATUS, 32'h3);
      wr(OFS_INT_MASK, 32'h1);
      wr(OFS_EVCFG, 32'h50);
      #1 chk("irq idle", 32'h0, {31'h0, irq});
      wr(OFS_CTRL, 32'h04);
      #1 chk("chan routed", 32'h20, {16'h0, irq_chan});
      chk("irq raised", 32'h1, {31'h0, irq});
      rdc("int status", OFS_INT_STATUS, 32'h1);
      wr(OFS_CTRL, 32'h0);
      #1 chk("chan follows", 32'h0, {16'h0, irq_chan});
      chk("irq sticky", 32'h1, {31'h0, irq});
      wr(OFS_INT_STATUS, 32'h1);
      #1 chk("irq cleared", 32'h0, {31'h0, irq});
      wr(OFS_INT_MASK, 32'h0);
      wr(OFS_EVCFG, 32'h00);
      wr(OFS_CTRL, 32'h01);
      #1 chk("chan unmapped", 32'h0, {16'h0, irq_chan});
      chk("irq masked", 32'h0, {31'h0, irq});
      rdc("masked status", OFS_INT_STATUS, 32'h1);
   endtask : t_irq

   // Prints counts and verdict, then ends the run
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : wrap_up

   // Watchdog against a hung run
   initial begin
      #50000;
      fail_count++;
      wrap_up();
   end

   // Main sequence
   initial begin
      fail_count = 0;
      n_compared = 0;
      reset_n = 1'b0;
      reg_addr = 8'h0;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      kbd_irq = 1'b0;
      mouse_irq = 1'b0;
      repeat (2) @(posedge ref_clk);
      reset_n <= 1'b1;
      t_reset_values();
      t_countdown();
      t_minutes();
      t_disable();
      t_force();
      t_events();
      t_irq();
      wrap_up();
   end
endmodule : tb_top
